// >>> pkg/alu_exec_pkg.sv
/*
  Package for the instruction execution datapath: operation codes, widths,
  flag reset values and instruction cycle timing.
  Assumes a decoder outside that presents one decoded operation at a time.
*/
`default_nettype none
package alu_exec_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned PC_W           = 13;
  localparam int unsigned CLKS_PER_CYCLE = 4;   // System clocks per instruction cycle.
  localparam logic [1:0]  PHASE_LAST     = 2'h3;
  localparam logic [3:0]  BCD_LIMIT      = 4'h9;
  localparam logic [3:0]  BCD_FIX        = 4'h6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] WORK_RST   = 8'h00;
  localparam logic       CARRY_RST  = 1'b0;
  localparam logic       ZERO_RST   = 1'b0;
  localparam logic       PWRDN_RST  = 1'b0;
  localparam logic       TMOUT_RST  = 1'b0;
  localparam logic       GIE_RST    = 1'b0;
  localparam logic [12:0] PC_RST    = 13'h0000;

  // ****************************************************************
  // Decoded operations
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_IDLE          = 5'b00000,
    OP_INVERT_ACC    = 5'b00001,
    OP_BCD_ADJUST    = 5'b00010,
    OP_INC_MEM       = 5'b00011,
    OP_DEC_MEM       = 5'b00100,
    OP_INC_ACC       = 5'b00101,
    OP_DEC_ACC       = 5'b00110,
    OP_SLEEP         = 5'b00111,
    OP_JUMP          = 5'b01000,
    OP_MOV_M_TO_A    = 5'b01001,
    OP_MOV_X_TO_A    = 5'b01010,
    OP_MOV_A_TO_M    = 5'b01011,
    OP_OR_M_ACC      = 5'b01100,
    OP_OR_X_ACC      = 5'b01101,
    OP_OR_TO_MEM     = 5'b01110,
    OP_SUB_EXIT      = 5'b01111,
    OP_SUB_EXIT_VAL  = 5'b10000,
    OP_INT_EXIT      = 5'b10001,
    OP_ROT_L_MEM     = 5'b10010,
    OP_ROT_L_ACC     = 5'b10011,
    OP_ROT_LC_MEM    = 5'b10100,
    OP_ROT_LC_ACC    = 5'b10101,
    OP_ROT_R_MEM     = 5'b10110
  } exec_op_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_EXTRA  = 2'b01,
    ST_ASLEEP = 2'b10
  } exec_state_t;

endpackage : alu_exec_pkg
`default_nettype wire

// >>> src/alu_exec.sv
/*
  Execution datapath for one slice of an 8-bit core's instruction set.
  Holds the work register, carry, zero, power-down, watchdog time-out and
  global interrupt enable, plus the program counter. Each instruction is
  taken at the end of an instruction cycle of four system clocks.
  Assumes: the decoder holds op, operand and immediate stable while
  op_valid is high and watches op_ready; memory read data is already valid;
  the stack supplies stack_top combinationally.
*/
// Local design decisions: the plain strobed memory write port.
//
// Contract
// - Invert-to-acc puts inverted memory byte in work register, changes zero only.
// - BCD low nibble: above 9 or half carry adds 6, internal carry is not-half.
// - BCD high nibble: plus internal carry above 9 or carry adds 6, sets carry.
// - BCD result goes to memory; carry is the only flag touched.
// - Memory increment/decrement modulo 256 written back, zero flag only.
// - Acc-destination increment/decrement leaves memory, writes work register, zero only.
// - Sleep stops execution, advances PC by one, gates clock, keeps all state.
// - Sleep clears watchdog and prescaler, sets power-down, clears time-out.
// - Jump loads PC with instruction address, no flag changes.
// - Moves copy memory or immediate to acc, or acc to memory, no flags.
// - Idle only advances PC by one.
// - OR forms acc OR operand into acc or memory, zero flag only.
// - Subroutine exit pops PC, takes two instruction cycles, no flags.
// - Return-with-value pops PC and loads immediate into acc, no flags.
// - Interrupt exit pops PC and sets global interrupt enable.
// - Left rotate wraps bit 7 into bit 0, to memory or acc, no flags.
// - Left rotate through carry moves bit 7 to carry, old carry to bit 0.
// - Right rotate wraps bit 0 into bit 7, written back to memory.
// - Instruction cycle is four clocks; PC loads add one extra cycle.
`timescale 1ns/10ps
`default_nettype none
module alu_exec #(
  parameter int unsigned PC_WIDTH = alu_exec_pkg::PC_W
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  input  wire logic                       op_valid,
  input  wire alu_exec_pkg::exec_op_t     op_code,
  input  wire logic [7:0]                 mem_rdata,
  input  wire logic [7:0]                 imm_data,
  input  wire logic [PC_WIDTH-1:0]        jump_addr,
  input  wire logic [PC_WIDTH-1:0]        stack_top,
  input  wire logic                       wake,
  output logic                            op_ready,
  output logic                            mem_we,
  output logic [7:0]                      mem_wdata,
  output logic                            stack_pop,
  output logic                            wdt_clear,
  output logic                            sys_clk_gate,
  output logic [7:0]                      work_register,
  output logic                            carry_flag,
  output logic                            zero_flag,
  output logic                            power_down_flag,
  output logic                            watchdog_timeout_flag,
  output logic                            global_interrupt_enable,
  output logic [PC_WIDTH-1:0]             pc
);
  import alu_exec_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Decoding that only the extra-cycle timing needs; the PC update decodes jump and pops itself.
  function automatic logic loads_pc(input exec_op_t op);
    loads_pc = (op == OP_JUMP) || (op == OP_SUB_EXIT) ||
               (op == OP_SUB_EXIT_VAL) || (op == OP_INT_EXIT);
  endfunction : loads_pc

  // Only the three exits take their new PC from the stack.
  function automatic logic pops_stack(input exec_op_t op);
    pops_stack = (op == OP_SUB_EXIT) || (op == OP_SUB_EXIT_VAL) ||
                 (op == OP_INT_EXIT);
  endfunction : pops_stack

  // ****************************************************************
  // Instruction cycle sequencing
  // ****************************************************************
  exec_state_t    state_q;
  logic [1:0]     phase_q;
  logic           issue;
  logic           cycle_end;
  logic [7:0]     acc_q;
  logic           carry_q;
  logic           zero_q;
  logic           pwrdn_q;
  logic           tmout_q;
  logic           gie_q;
  logic [PC_WIDTH-1:0] pc_q;

  // An instruction cycle ends on the fourth system clock.
  assign cycle_end = (phase_q == PHASE_LAST);
  // Ready is combinational so the decoder sees it in the same cycle; op_valid
  // on its own never changes any state.
  assign op_ready  = clk_en && cycle_end && (state_q == ST_RUN);
  assign issue     = op_ready && op_valid;

  // Phase counter runs free so instruction cycles stay aligned to four clocks.
  // It stops while asleep, so waking resumes at the start of a cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase_q <= 2'h0;
    end else if (clk_en && (state_q != ST_ASLEEP)) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // The extra cycle after a PC load models the refetch of the discarded word.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
    end else if (clk_en) begin
      unique case (state_q)
        ST_RUN: begin
          // Sleep needs no extra cycle: the PC has already stepped past it.
          if (issue && op_code == OP_SLEEP) begin
            state_q <= ST_ASLEEP;
          end else if (issue && loads_pc(op_code)) begin
            state_q <= ST_EXTRA;
          end
        end
        // The discarded word occupies one whole instruction cycle.
        ST_EXTRA: begin
          if (cycle_end) begin
            state_q <= ST_RUN;
          end
        end
        // Wake is a level; the phase counter restarts from zero on leaving.
        ST_ASLEEP: begin
          if (wake) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // ****************************************************************
  // Datapath results
  // ****************************************************************
  logic [7:0] inc_val;
  logic [7:0] dec_val;
  logic [7:0] or_mem;
  logic [7:0] or_imm;
  logic [4:0] lo_sum;
  logic       lo_adj;
  logic       lo_carry;
  logic [3:0] lo_res;
  logic [4:0] hi_base;
  logic       hi_adj;
  logic [3:0] hi_res;
  logic       half_carry_flag;

  // Half carry is kept by the arithmetic group outside; this slice never sets it.
  assign half_carry_flag = 1'b0;
  // BCD adjust therefore relies on the low nibble alone to decide its low-nibble fix-up.

  // Results of the simple operations, shared by the memory and register paths.
  // Both wrap modulo 256, which the eight-bit sum gives for free.
  assign inc_val = mem_rdata + 8'h01;
  assign dec_val = mem_rdata - 8'h01;
  assign or_mem  = acc_q | mem_rdata;
  assign or_imm  = acc_q | imm_data;

  // Low nibble adjust and the internal carry that feeds the high nibble.
  always_comb begin
    lo_adj = (acc_q[3:0] > BCD_LIMIT) || half_carry_flag;
    lo_sum = {1'b0, acc_q[3:0]} + (lo_adj ? {1'b0, BCD_FIX} : 5'h00);
    lo_res = lo_sum[3:0];
    lo_carry = lo_adj ? ~half_carry_flag : 1'b0;
  end

  // High nibble adjust; BCD adjust only ever sets carry here, never clears it.
  always_comb begin
    hi_base = {1'b0, acc_q[7:4]} + {4'h0, lo_carry};
    hi_adj  = (hi_base > {1'b0, BCD_LIMIT}) || carry_q;
    hi_res  = hi_adj ? (hi_base[3:0] + BCD_FIX) : hi_base[3:0];
  end

  // ****************************************************************
  // Memory write port
  // ****************************************************************

  // Write data is registered so memory sees a stable value for a whole cycle.
  // Only memory-destination operations raise the strobe; the rest keep the
  // last write data, which memory ignores while the strobe is low.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mem_we    <= 1'b0;
      mem_wdata <= 8'h00;
    end else if (clk_en) begin
      mem_we <= 1'b0;
      if (issue) begin
        unique case (op_code)
          OP_BCD_ADJUST: begin
            mem_we    <= 1'b1;
            mem_wdata <= {hi_res, lo_res};
          end
          OP_INC_MEM: begin
            mem_we    <= 1'b1;
            mem_wdata <= inc_val;
          end
          OP_DEC_MEM: begin
            mem_we    <= 1'b1;
            mem_wdata <= dec_val;
          end
          OP_MOV_A_TO_M: begin
            mem_we    <= 1'b1;
            mem_wdata <= acc_q;
          end
          OP_OR_TO_MEM: begin
            mem_we    <= 1'b1;
            mem_wdata <= or_mem;
          end
          OP_ROT_L_MEM: begin
            mem_we    <= 1'b1;
            mem_wdata <= {mem_rdata[6:0], mem_rdata[7]};
          end
          OP_ROT_LC_MEM: begin
            mem_we    <= 1'b1;
            mem_wdata <= {mem_rdata[6:0], carry_q};
          end
          OP_ROT_R_MEM: begin
            mem_we    <= 1'b1;
            mem_wdata <= {mem_rdata[0], mem_rdata[7:1]};
          end
          default: mem_we <= 1'b0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Work register and zero flag
  // ****************************************************************

  // Zero follows the value written by the operations that own it.
  // Operations outside this list, idle among them, leave register and flag.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      acc_q  <= WORK_RST;
      zero_q <= ZERO_RST;
    end else if (clk_en && issue) begin
      unique case (op_code)
        OP_INVERT_ACC: begin
          acc_q  <= ~mem_rdata;
          zero_q <= (~mem_rdata == 8'h00);
        end
        OP_INC_MEM:      zero_q <= (inc_val == 8'h00);
        OP_DEC_MEM:      zero_q <= (dec_val == 8'h00);
        OP_INC_ACC: begin
          acc_q  <= inc_val;
          zero_q <= (inc_val == 8'h00);
        end
        OP_DEC_ACC: begin
          acc_q  <= dec_val;
          zero_q <= (dec_val == 8'h00);
        end
        OP_MOV_M_TO_A:   acc_q <= mem_rdata;
        OP_MOV_X_TO_A:   acc_q <= imm_data;
        OP_OR_M_ACC: begin
          acc_q  <= or_mem;
          zero_q <= (or_mem == 8'h00);
        end
        OP_OR_X_ACC: begin
          acc_q  <= or_imm;
          zero_q <= (or_imm == 8'h00);
        end
        OP_OR_TO_MEM:    zero_q <= (or_mem == 8'h00);
        OP_SUB_EXIT_VAL: acc_q <= imm_data;
        OP_ROT_L_ACC:    acc_q <= {mem_rdata[6:0], mem_rdata[7]};
        OP_ROT_LC_ACC:   acc_q <= {mem_rdata[6:0], carry_q};
        default: begin
          acc_q  <= acc_q;
          zero_q <= zero_q;
        end
      endcase
    end
  end

  // ****************************************************************
  // Carry flag
  // ****************************************************************

  // Carry moves only for BCD adjust and the rotates through carry, so a
  // rotate's old carry is still there for the next one.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      carry_q <= CARRY_RST;
    end else if (clk_en && issue) begin
      if (op_code == OP_BCD_ADJUST && hi_adj) begin
        carry_q <= 1'b1;
      end else if (op_code == OP_ROT_LC_MEM || op_code == OP_ROT_LC_ACC) begin
        carry_q <= mem_rdata[7];
      end
    end
  end

  // ****************************************************************
  // Power, watchdog and interrupt state
  // ****************************************************************

  // Only sleep touches these two flags inside this slice.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pwrdn_q <= PWRDN_RST;
      tmout_q <= TMOUT_RST;
    end else if (clk_en && issue && op_code == OP_SLEEP) begin
      pwrdn_q <= 1'b1;
      tmout_q <= 1'b0;
    end
  end

  // Interrupt exit is the only way this slice raises the global enable;
  // clearing it on interrupt entry belongs to the interrupt controller.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      gie_q <= GIE_RST;
    end else if (clk_en && issue && op_code == OP_INT_EXIT) begin
      gie_q <= 1'b1;
    end
  end

  // One-cycle pulses toward the watchdog and the stack.
  // The watchdog clear pulse also resets its prescaler outside this block.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wdt_clear <= 1'b0;
      stack_pop <= 1'b0;
    end else if (clk_en) begin
      wdt_clear <= issue && (op_code == OP_SLEEP);
      stack_pop <= issue && pops_stack(op_code);
    end
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************

  // Popping and jumping load the PC; everything else, sleep included, steps by one.
  // The PC wraps at its width; the decoder never issues beyond the last word.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pc_q <= PC_WIDTH'(PC_RST);
    end else if (clk_en && issue) begin
      if (op_code == OP_JUMP) begin
        pc_q <= jump_addr;
      end else if (pops_stack(op_code)) begin
        pc_q <= stack_top;
      end else begin
        pc_q <= pc_q + PC_WIDTH'(1);
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Gate drops while asleep; every register but the one-cycle pulse outputs holds its value.
  // Flags come straight from their registers so they never glitch.
  assign sys_clk_gate            = (state_q != ST_ASLEEP);
  assign work_register           = acc_q;
  assign carry_flag              = carry_q;
  assign zero_flag               = zero_q;
  assign power_down_flag         = pwrdn_q;
  assign watchdog_timeout_flag   = tmout_q;
  assign global_interrupt_enable = gie_q;
  assign pc                      = pc_q;

endmodule : alu_exec
`default_nettype wire

// >>> testbench/alu_exec_assertions.sv
/*
  Checker for alu_exec: timing and result relations seen at its ports.
  Assumes it is bound into every alu_exec instance by the bind below.
*/
`timescale 1ns/10ps
`default_nettype none
module alu_exec_assertions #(
  parameter int unsigned PC_WIDTH = 13
) (
  input wire logic                   clk_sys,
  input wire logic                   rst_b,
  input wire logic                   op_valid,
  input wire alu_exec_pkg::exec_op_t op_code,
  input wire logic [7:0]             mem_rdata,
  input wire logic [PC_WIDTH-1:0]    jump_addr,
  input wire logic [PC_WIDTH-1:0]    stack_top,
  input wire logic                   op_ready,
  input wire logic                   mem_we,
  input wire logic [7:0]             mem_wdata,
  input wire logic                   stack_pop,
  input wire logic                   wdt_clear,
  input wire logic                   sys_clk_gate,
  input wire logic [7:0]             work_register,
  input wire logic                   carry_flag,
  input wire logic                   zero_flag,
  input wire logic                   power_down_flag,
  input wire logic                   watchdog_timeout_flag,
  input wire logic                   global_interrupt_enable,
  input wire logic [PC_WIDTH-1:0]    pc
);
  import alu_exec_pkg::*;
  // ********************
  // Properties
  // ********************
  // An operation counts only where ready meets valid.
  logic take;
  assign take = op_ready && op_valid;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_READY_GAP: assert property (op_ready |=> !op_ready [*3])
    else $error("ready returned inside one instruction cycle");
  AST_LOAD_EXTRA: assert property (take && op_code inside {OP_JUMP, OP_SUB_EXIT,
    OP_SUB_EXIT_VAL, OP_INT_EXIT} |=> !op_ready [*7]) else $error("no extra cycle");
  AST_JUMP_PC: assert property (take && op_code == OP_JUMP |=> pc == $past(jump_addr))
    else $error("jump target not loaded");
  AST_INC_MEM: assert property (take && op_code == OP_INC_MEM
    |=> mem_we && mem_wdata == $past(mem_rdata) + 8'h01) else $error("bad increment");
  AST_INVERT: assert property (take && op_code == OP_INVERT_ACC
    |=> !mem_we && work_register == ~$past(mem_rdata)) else $error("bad inversion");
  AST_SLEEP: assert property (take && op_code == OP_SLEEP |=> power_down_flag
    && !watchdog_timeout_flag && wdt_clear && !sys_clk_gate) else $error("bad sleep");
  AST_ASLEEP: assert property (!sys_clk_gate |-> !op_ready ##1 ($stable(pc)
    && $stable(work_register) && $stable(carry_flag))) else $error("state moved asleep");
  AST_INT_EXIT: assert property (take && op_code == OP_INT_EXIT |=> stack_pop
    && global_interrupt_enable && pc == $past(stack_top)) else $error("bad return");
  AST_ROT_R: assert property (take && op_code == OP_ROT_R_MEM |=> mem_we
    && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}) else $error("bad rotate");
  AST_MOVE_FLAGS: assert property (take && op_code inside {OP_MOV_M_TO_A,
    OP_MOV_X_TO_A, OP_MOV_A_TO_M} |=> $stable(carry_flag) && $stable(zero_flag))
    else $error("move changed a flag");
endmodule : alu_exec_assertions
bind alu_exec alu_exec_assertions #(.PC_WIDTH(PC_WIDTH)) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
  .mem_rdata(mem_rdata), .jump_addr(jump_addr), .stack_top(stack_top),
  .op_ready(op_ready), .mem_we(mem_we), .mem_wdata(mem_wdata), .stack_pop(stack_pop),
  .wdt_clear(wdt_clear), .sys_clk_gate(sys_clk_gate), .work_register(work_register),
  .carry_flag(carry_flag), .zero_flag(zero_flag), .power_down_flag(power_down_flag),
  .watchdog_timeout_flag(watchdog_timeout_flag), .pc(pc),
  .global_interrupt_enable(global_interrupt_enable));
`default_nettype wire

// >>> testbench/mcu_alu_instruction_exec_tb.sv
/*
  Self-checking bench for alu_exec: issues decoded operations, checks results.
  Assumes the bench stands in for decoder, data memory and stack.
*/
`timescale 1ns/10ps
`default_nettype none
module mcu_alu_instruction_exec_tb;
  import alu_exec_pkg::*;
  logic        clk_sys, rst_b, clk_en, op_valid, wake, op_ready, mem_we, stack_pop;
  logic        wdt_clear, sys_clk_gate, carry_flag, zero_flag, power_down_flag;
  logic        watchdog_timeout_flag, global_interrupt_enable, e_pd, e_gie;
  exec_op_t    op_code;
  logic [7:0]  mem_rdata, imm_data, work_register, mem_wdata;
  logic [12:0] jump_addr, stack_top, pc, e_pc;
  int          err_total, check_count, wait_n;
  alu_exec dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .mem_rdata(mem_rdata), .imm_data(imm_data), .jump_addr(jump_addr),
    .stack_top(stack_top), .wake(wake), .op_ready(op_ready), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .stack_pop(stack_pop), .wdt_clear(wdt_clear),
    .sys_clk_gate(sys_clk_gate), .work_register(work_register), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .power_down_flag(power_down_flag), .pc(pc),
    .watchdog_timeout_flag(watchdog_timeout_flag),
    .global_interrupt_enable(global_interrupt_enable));
  // ********************
  // Helpers
  // ********************
  // Free-running system clock, 4 ns period.
  always #2 clk_sys = ~clk_sys;
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // One operation, held until taken; then every result port but sys_clk_gate and op_ready is compared, write data only when written.
  task step(input exec_op_t o, input logic [7:0] m, x, input bit we, input logic [7:0] wd,
            input logic [7:0] acc, input bit c, z);
    int   n;
    logic ld;
    n = 0;
    ld = o inside {OP_JUMP, OP_SUB_EXIT, OP_SUB_EXIT_VAL, OP_INT_EXIT};
    op_code <= o;
    mem_rdata <= m;
    imm_data <= x;
    op_valid <= 1'b1;
    do begin
      @(negedge clk_sys);
      n++;
    end while (op_ready !== 1'b1 && n < 40);
    wait_n = n;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    mem_rdata <= ~m; // Stale memory data must not pass for a result.
    if (!ld) e_pc = e_pc + 13'h0001;
    @(negedge clk_sys);
    chk("acc", work_register, acc);
    chk("carry", carry_flag, c);
    chk("zero", zero_flag, z);
    chk("pc", pc, e_pc);
    chk("write", mem_we, we);
    if (we) chk("wdata", mem_wdata, wd);
    chk("pdf", power_down_flag, e_pd);
    chk("timeout", watchdog_timeout_flag, 1'b0);
    chk("gie", global_interrupt_enable, e_gie);
    chk("pop", stack_pop, ld && o != OP_JUMP);
    chk("wdt", wdt_clear, o == OP_SLEEP);
    @(posedge clk_sys);
  endtask : step
  // ********************
  // Scenarios
  // ********************
  task t_data;
    step(OP_INVERT_ACC, 8'h0f, 8'h00, 0, 8'h00, 8'hf0, 0, 0);
    step(OP_INVERT_ACC, 8'hff, 8'h00, 0, 8'h00, 8'h00, 0, 1);
    step(OP_MOV_X_TO_A, 8'h00, 8'h3c, 0, 8'h00, 8'h3c, 0, 1);
    step(OP_MOV_M_TO_A, 8'h81, 8'h00, 0, 8'h00, 8'h81, 0, 1);
    step(OP_MOV_A_TO_M, 8'h55, 8'h00, 1, 8'h81, 8'h81, 0, 1);
    step(OP_DEC_MEM, 8'h00, 8'h00, 1, 8'hff, 8'h81, 0, 0);
    step(OP_INC_MEM, 8'hff, 8'h00, 1, 8'h00, 8'h81, 0, 1);
    step(OP_DEC_ACC, 8'h00, 8'h00, 0, 8'h00, 8'hff, 0, 0);
    step(OP_INC_ACC, 8'hff, 8'h00, 0, 8'h00, 8'h00, 0, 1);
    step(OP_OR_X_ACC, 8'h00, 8'h0a, 0, 8'h00, 8'h0a, 0, 0);
    step(OP_OR_M_ACC, 8'ha0, 8'h00, 0, 8'h00, 8'haa, 0, 0);
    step(OP_OR_TO_MEM, 8'h05, 8'h00, 1, 8'haf, 8'haa, 0, 0);
    $display("test data done");
  endtask : t_data
  task t_rotate;
    step(OP_ROT_L_MEM, 8'h81, 8'h00, 1, 8'h03, 8'haa, 0, 0);
    step(OP_ROT_L_ACC, 8'h80, 8'h00, 0, 8'h00, 8'h01, 0, 0);
    step(OP_ROT_LC_MEM, 8'h80, 8'h00, 1, 8'h00, 8'h01, 1, 0);
    step(OP_ROT_LC_ACC, 8'h01, 8'h00, 0, 8'h00, 8'h03, 0, 0);
    step(OP_ROT_R_MEM, 8'h01, 8'h00, 1, 8'h80, 8'h03, 0, 0);
    $display("test rotate done");
  endtask : t_rotate
  // Half carry is held low in this slice, so nibble values and the carry flag steer it.
  task t_bcd;
    step(OP_MOV_X_TO_A, 8'h00, 8'h45, 0, 8'h00, 8'h45, 0, 0);
    step(OP_BCD_ADJUST, 8'h00, 8'h00, 1, 8'h45, 8'h45, 0, 0);
    step(OP_MOV_X_TO_A, 8'h00, 8'h3b, 0, 8'h00, 8'h3b, 0, 0);
    step(OP_BCD_ADJUST, 8'h00, 8'h00, 1, 8'h41, 8'h3b, 0, 0);
    step(OP_MOV_X_TO_A, 8'h00, 8'h9a, 0, 8'h00, 8'h9a, 0, 0);
    step(OP_BCD_ADJUST, 8'h00, 8'h00, 1, 8'h00, 8'h9a, 1, 0);
    step(OP_MOV_X_TO_A, 8'h00, 8'h12, 0, 8'h00, 8'h12, 1, 0);
    step(OP_BCD_ADJUST, 8'h00, 8'h00, 1, 8'h72, 8'h12, 1, 0);
    $display("test bcd done");
  endtask : t_bcd
  // Waits count negedges from the call to ready: three per cycle, seven after a load.
  task t_flow;
    jump_addr <= 13'h1abc;
    e_pc = 13'h1abc;
    step(OP_JUMP, 8'h00, 8'h00, 0, 8'h00, 8'h12, 1, 0);
    step(OP_IDLE, 8'h00, 8'h00, 0, 8'h00, 8'h12, 1, 0);
    chk("wait", 16'(wait_n), 16'(2 * CLKS_PER_CYCLE - 1));
    step(OP_IDLE, 8'h00, 8'h00, 0, 8'h00, 8'h12, 1, 0);
    chk("wait", 16'(wait_n), 16'(CLKS_PER_CYCLE - 1));
    stack_top <= 13'h0123;
    e_pc = 13'h0123;
    step(OP_SUB_EXIT, 8'h00, 8'h00, 0, 8'h00, 8'h12, 1, 0);
    stack_top <= 13'h0777;
    e_pc = 13'h0777;
    step(OP_SUB_EXIT_VAL, 8'h00, 8'h5a, 0, 8'h00, 8'h5a, 1, 0);
    chk("wait", 16'(wait_n), 16'(2 * CLKS_PER_CYCLE - 1));
    stack_top <= 13'h0456;
    e_pc = 13'h0456;
    e_gie = 1'b1;
    step(OP_INT_EXIT, 8'h00, 8'h00, 0, 8'h00, 8'h5a, 1, 0);
    $display("test flow done");
  endtask : t_flow
  // Frozen by clock enable, then asleep until woken; state must survive both.
  task t_sleep;
    clk_en <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("frozen", op_ready, 1'b0);
    clk_en <= 1'b1;
    e_pd = 1'b1;
    step(OP_SLEEP, 8'h00, 8'h00, 0, 8'h00, 8'h5a, 1, 0);
    chk("wait", 16'(wait_n), 16'(2 * CLKS_PER_CYCLE - 1));
    repeat (12) @(posedge clk_sys);
    chk("gate", sys_clk_gate, 1'b0);
    chk("ready", op_ready, 1'b0);
    chk("pc", pc, e_pc);
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    step(OP_IDLE, 8'h00, 8'h00, 0, 8'h00, 8'h5a, 1, 0);
    chk("gate", sys_clk_gate, 1'b1);
    $display("test sleep done");
  endtask : t_sleep
  // ********************
  // Main sequence
  // ********************
  // Reset, then every scenario in turn.
  initial begin
    {clk_sys, rst_b, clk_en, op_valid, wake} = 5'h04;
    {mem_rdata, imm_data, jump_addr, stack_top} = 42'h0;
    op_code = OP_IDLE;
    {err_total, check_count, e_pc, e_pd, e_gie} = 0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("acc", work_register, 8'h00);
    chk("flags", {carry_flag, zero_flag, power_down_flag, global_interrupt_enable}, 4'h0);
    chk("pc", pc, 13'h0000);
    chk("gate", sys_clk_gate, 1'b1);
    t_data();
    t_rotate();
    t_bcd();
    t_flow();
    t_sleep();
    summarize();
  end
  // Watchdog: the run needs well under 2000 cycles.
  initial begin
    #40000;
    err_total++;
    summarize();
  end
endmodule : mcu_alu_instruction_exec_tb
`default_nettype wire
